/* rtl/ppcei_top.sv */
// port pin configuration registers, pin muxing and edge interrupts
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ppcei_top
  import ppcei_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire logic [3:0]        p0_pin_i,
  input  wire logic [3:0]        p0_is_input_i,
  output logic [7:0]             p0_pullup_o,
  input  wire logic [2:0]        p1_data_i,
  output logic [2:0]             p1_out_o,
  output logic [2:0]             p1_oe_o,
  output logic [1:0]             p1_pullup_o,
  output logic [1:0]             p1_pulldown_o,
  output logic [2:0]             p1_in_en_o,
  input  wire logic [6:0]        p2_data_i,
  input  wire logic [6:0]        p2_pin_i,
  input  wire logic              clock_out_pin_fn_i,
  input  wire logic              uart_txd_i,
  input  wire logic              uart_rxd_out_i,
  input  wire logic              timer_one_match_i,
  input  wire logic              timer_zero_match_i,
  output logic [6:0]             p2_out_o,
  output logic [6:0]             p2_oe_o,
  output logic [6:0]             p2_pullup_o,
  output logic [6:0]             p2_in_en_o,
  output logic [2:0]             conv_sel_o,
  output logic                   uart_rxd_o,
  output logic                   timer_one_capture_o,
  output logic                   irq_o
);
  logic       rst_meta_r;
  logic       rst_n_r;
  logic [7:0] port2_pullup_ctrl_r;
  logic [7:0] port0_pullup_ctrl_r;
  logic [3:0] flag_en_r;
  logic [7:0] port1_mode_ctrl_r;
  logic [7:0] port2_mode_ctrl_upper_r;
  logic [7:0] port2_mode_ctrl_lower_r;
  logic [7:0] port3_mode_ctrl_r;
  logic [3:0] irq_en_r;
  logic [3:0] pend;
  logic [3:0] pend_clr;
  logic [7:0] flags_view;
  logic [3:0] alt_src;

  ppcei_reg_if rif ();

  // reset enters asynchronously, leaves through two flops
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  ppcei_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_r),
    .awaddr_i  (s_axi_awaddr_i),
    .awvalid_i (s_axi_awvalid_i),
    .awready_o (s_axi_awready_o),
    .wdata_i   (s_axi_wdata_i),
    .wstrb_i   (s_axi_wstrb_i),
    .wvalid_i  (s_axi_wvalid_i),
    .wready_o  (s_axi_wready_o),
    .bresp_o   (s_axi_bresp_o),
    .bvalid_o  (s_axi_bvalid_o),
    .bready_i  (s_axi_bready_i),
    .araddr_i  (s_axi_araddr_i),
    .arvalid_i (s_axi_arvalid_i),
    .arready_o (s_axi_arready_o),
    .rdata_o   (s_axi_rdata_o),
    .rresp_o   (s_axi_rresp_o),
    .rvalid_o  (s_axi_rvalid_o),
    .rready_i  (s_axi_rready_i),
    .rif       (rif.bus)
  );

  always_comb
  begin
    unique case (rif.wr_idx)
      IDX_P2_PULLUP, IDX_P0_PULLUP, IDX_P0_FLAGS, IDX_P1_MODE,
      IDX_P2_UPPER, IDX_P2_LOWER, IDX_P3_MODE, IDX_IRQ_CLR,
      IDX_IRQ_EN:
        rif.wr_hit = 1'b1;
      default:
        rif.wr_hit = 1'b0;
    endcase
  end

  // configuration registers, unused bits held at zero; port3_mode_ctrl_r keeps all eight bits as written
  always_ff @(posedge clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      port2_pullup_ctrl_r     <= RST_P2_PULLUP;
      port0_pullup_ctrl_r     <= RST_P0_PULLUP;
      port1_mode_ctrl_r       <= RST_P1_MODE;
      port2_mode_ctrl_upper_r <= RST_P2_UPPER;
      port2_mode_ctrl_lower_r <= RST_P2_LOWER;
      port3_mode_ctrl_r       <= RST_P3_MODE;
    end
    else if (rif.wr_en)
    begin
      unique case (rif.wr_idx)
        IDX_P2_PULLUP:
          port2_pullup_ctrl_r <= rif.wr_data & MASK_P2_PULLUP;
        IDX_P0_PULLUP:
          port0_pullup_ctrl_r <= rif.wr_data;
        IDX_P1_MODE:
          port1_mode_ctrl_r <= rif.wr_data & MASK_P1_MODE;
        IDX_P2_UPPER:
          port2_mode_ctrl_upper_r <= rif.wr_data & MASK_P2_UPPER;
        IDX_P2_LOWER:
          port2_mode_ctrl_lower_r <= rif.wr_data;
        IDX_P3_MODE:
          port3_mode_ctrl_r <= rif.wr_data;
        default:
          port3_mode_ctrl_r <= port3_mode_ctrl_r;
      endcase
    end
  end

  // enable bits sit at the odd positions of the flag register
  always_ff @(posedge clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      flag_en_r <= RST_FLAG_EN;
      irq_en_r  <= RST_IRQ_EN;
    end
    else if (rif.wr_en)
    begin
      if (rif.wr_idx == IDX_P0_FLAGS)
        for (int k = 0; k < NUM_EXT_IRQ; k++)
          flag_en_r[k] <= rif.wr_data[2*k+FLAG_EN_OFS];
      if (rif.wr_idx == IDX_IRQ_EN)
        irq_en_r <= rif.wr_data[3:0];
    end
  end

  // zero in a pending position clears, the clear register takes ones
  always_comb
  begin
    pend_clr = 4'h0;
    for (int k = 0; k < NUM_EXT_IRQ; k++)
    begin
      if (rif.wr_en && rif.wr_idx == IDX_P0_FLAGS)
        pend_clr[k] = ~rif.wr_data[2*k+FLAG_PD_OFS];
      if (rif.wr_en && rif.wr_idx == IDX_IRQ_CLR)
        pend_clr[k] = rif.wr_data[k];
    end
  end

  // edges counted only while the port-0 pin is an input
  ppcei_edge_irq #(
    .N (NUM_EXT_IRQ)
  ) u_edge (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_r),
    .pin_i   (p0_pin_i),
    .watch_i (p0_is_input_i),
    .en_i    (flag_en_r),
    .clr_i   (pend_clr),
    .pend_o  (pend)
  );

  // pending and enable bits interleave in the read view
  always_comb
  begin
    flags_view = 8'h00;
    for (int k = 0; k < NUM_EXT_IRQ; k++)
    begin
      flags_view[2*k+FLAG_EN_OFS] = flag_en_r[k];
      flags_view[2*k+FLAG_PD_OFS] = pend[k];
    end
  end

  always_comb
  begin
    rif.rd_hit  = 1'b1;
    rif.rd_data = 8'h00;
    unique case (rif.rd_idx)
      IDX_P2_PULLUP: rif.rd_data = port2_pullup_ctrl_r;
      IDX_P0_PULLUP: rif.rd_data = port0_pullup_ctrl_r;
      IDX_P0_FLAGS:  rif.rd_data = flags_view;
      IDX_P1_MODE:   rif.rd_data = port1_mode_ctrl_r;
      IDX_P2_UPPER:  rif.rd_data = port2_mode_ctrl_upper_r;
      IDX_P2_LOWER:  rif.rd_data = port2_mode_ctrl_lower_r;
      IDX_P3_MODE:   rif.rd_data = port3_mode_ctrl_r;
      IDX_IRQ_STAT:  rif.rd_data = {4'h0, pend};
      IDX_IRQ_CLR:   rif.rd_data = 8'h00;
      IDX_IRQ_EN:    rif.rd_data = {4'h0, irq_en_r};
      default:       rif.rd_hit  = 1'b0;
    endcase
  end

  // request stays up while an enabled pending bit is set
  always_ff @(posedge clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      irq_o <= 1'b0;
    else
      irq_o <= |(pend & irq_en_r);
  end

  // pull-up polarity differs between the two port-0 halves
  always_ff @(posedge clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      p0_pullup_o <= 8'h00;
    else
      p0_pullup_o <= {~port0_pullup_ctrl_r[7:P0_PU_SPLIT],
                      port0_pullup_ctrl_r[P0_PU_SPLIT-1:0]};
  end

  // open-drain drives only a low level; the high needs an outside pull-up, as p1_pullup_o is set only in P1M_IN_PU
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_p1
      ppcei_p1_mode_type md;
      logic              od;
      assign md = ppcei_p1_mode_type'(port1_mode_ctrl_r[2*g+1 -: 2]);
      assign od = port1_mode_ctrl_r[P1_OD0_BIT+g];
      // pin mode with chosen driver type
      always_ff @(posedge clk_i or negedge rst_n_r)
      begin
        if (!rst_n_r)
        begin
          p1_out_o[g]      <= 1'b0;
          p1_oe_o[g]       <= 1'b0;
          p1_pullup_o[g]   <= 1'b0;
          p1_pulldown_o[g] <= 1'b0;
          p1_in_en_o[g]    <= 1'b0;
        end
        else
        begin
          p1_out_o[g]      <= od ? 1'b0 : p1_data_i[g];
          p1_oe_o[g]       <= (md == P1M_OUT) & (~od | ~p1_data_i[g]);
          p1_pullup_o[g]   <= (md == P1M_IN_PU);
          p1_pulldown_o[g] <= (md == P1M_IN_PD);
          p1_in_en_o[g]    <= (md != P1M_OUT);
        end
      end
    end
  endgenerate

  // pin 2 of port 1 is input or open-drain only
  always_ff @(posedge clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      p1_out_o[2]   <= 1'b0;
      p1_oe_o[2]    <= 1'b0;
      p1_in_en_o[2] <= 1'b0;
    end
    else
    begin
      p1_out_o[2]   <= 1'b0;
      p1_oe_o[2]    <= port1_mode_ctrl_r[P1_P12_BIT] & ~p1_data_i[2];
      p1_in_en_o[2] <= ~port1_mode_ctrl_r[P1_P12_BIT];
    end
  end

  // alternate sources of port-2 pins 3..0
  assign alt_src = {uart_txd_i, uart_rxd_out_i, timer_one_match_i,
                    timer_zero_match_i};

  generate
    for (g = 0; g < 4; g++)
    begin : g_p2lo
      ppcei_p2_mode_type md;
      assign md = ppcei_p2_mode_type'(port2_mode_ctrl_lower_r[2*g+1 -: 2]);
      always_ff @(posedge clk_i or negedge rst_n_r)
      begin
        if (!rst_n_r)
        begin
          p2_out_o[g]   <= 1'b0;
          p2_oe_o[g]    <= 1'b0;
          p2_in_en_o[g] <= 1'b0;
        end
        else
        begin
          unique case (md)
            P2M_IN:
            begin
              p2_out_o[g] <= 1'b0;
              p2_oe_o[g]  <= 1'b0;
            end
            P2M_ALT:
            begin
              p2_out_o[g] <= alt_src[g];
              p2_oe_o[g]  <= 1'b1;
            end
            P2M_PP:
            begin
              p2_out_o[g] <= p2_data_i[g];
              p2_oe_o[g]  <= 1'b1;
            end
            P2M_OD:
            begin
              p2_out_o[g] <= 1'b0;
              p2_oe_o[g]  <= ~p2_data_i[g];
            end
          endcase
          p2_in_en_o[g] <= (md == P2M_IN);
        end
      end
    end
  endgenerate

  // pins 5,4: invalid code falls back to a plain input
  generate
    for (g = 0; g < 2; g++)
    begin : g_p2mid
      ppcei_p2_mode_type md;
      assign md = ppcei_p2_mode_type'(
        port2_mode_ctrl_upper_r[P2_P4_LSB+2*g+1 -: 2]);
      always_ff @(posedge clk_i or negedge rst_n_r)
      begin
        if (!rst_n_r)
        begin
          p2_out_o[4+g]   <= 1'b0;
          p2_oe_o[4+g]    <= 1'b0;
          p2_in_en_o[4+g] <= 1'b0;
          conv_sel_o[2-g] <= 1'b0;
        end
        else
        begin
          p2_out_o[4+g]   <= p2_data_i[4+g];
          p2_oe_o[4+g]    <= (md == P2M_PP);
          p2_in_en_o[4+g] <= (md == P2M_IN) | (md == P2M_OD);
          conv_sel_o[2-g] <= (md == P2M_ALT);
        end
      end
    end
  endgenerate

  // pin 6 with converter and clock output functions
  ppcei_p6_mode_type md6;
  assign md6 = ppcei_p6_mode_type'(port2_mode_ctrl_upper_r[P2_P6_LSB+2 -: 3]);

  always_ff @(posedge clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      p2_out_o[6]   <= 1'b0;
      p2_oe_o[6]    <= 1'b0;
      p2_in_en_o[6] <= 1'b0;
      conv_sel_o[0] <= 1'b0;
    end
    else
    begin
      unique case (md6)
        P6M_IN_A, P6M_IN_B, P6M_CONV_A, P6M_CONV_B:
        begin
          p2_out_o[6] <= 1'b0;
          p2_oe_o[6]  <= 1'b0;
        end
        P6M_PP:
        begin
          p2_out_o[6] <= p2_data_i[6];
          p2_oe_o[6]  <= 1'b1;
        end
        P6M_OD_PU, P6M_OD:
        begin
          p2_out_o[6] <= 1'b0;
          p2_oe_o[6]  <= ~p2_data_i[6];
        end
        P6M_CLK:
        begin
          p2_out_o[6] <= clock_out_pin_fn_i;
          p2_oe_o[6]  <= 1'b1;
        end
      endcase
      p2_in_en_o[6] <= (md6 == P6M_IN_A) | (md6 == P6M_IN_B);
      conv_sel_o[0] <= (md6 == P6M_CONV_A) | (md6 == P6M_CONV_B);
    end
  end

  // inverted pull-up bits; pin 6 mode P6M_OD_PU adds its own
  always_ff @(posedge clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      p2_pullup_o <= 7'h00;
    else
    begin
      p2_pullup_o    <= ~port2_pullup_ctrl_r[6:0];
      p2_pullup_o[6] <= ~port2_pullup_ctrl_r[6] | (md6 == P6M_OD_PU);
    end
  end

  // receive and capture follow pin 2 only in input mode
  always_ff @(posedge clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      uart_rxd_o          <= 1'b1;
      timer_one_capture_o <= 1'b1;
    end
    else
    begin
      uart_rxd_o          <= g_p2lo[2].md == P2M_IN ? p2_pin_i[2] : 1'b1;
      timer_one_capture_o <= g_p2lo[2].md == P2M_IN ? p2_pin_i[2] : 1'b1;
    end
  end

endmodule

/* rtl/ppcei_pkg.sv */
// shared constants and types for the port pin configuration block
package ppcei_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_P2_PULLUP = 8'he4;
  localparam logic [7:0] IDX_P0_PULLUP = 8'he5;
  localparam logic [7:0] IDX_P0_FLAGS  = 8'he8;
  localparam logic [7:0] IDX_P1_MODE   = 8'he9;
  localparam logic [7:0] IDX_P2_UPPER  = 8'hea;
  localparam logic [7:0] IDX_P2_LOWER  = 8'heb;
  localparam logic [7:0] IDX_P3_MODE   = 8'hf0;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'hf8;
  localparam logic [7:0] IDX_IRQ_CLR   = 8'hf9;
  localparam logic [7:0] IDX_IRQ_EN    = 8'hfa;

  // reset values
  localparam logic [7:0] RST_P2_PULLUP = 8'h00;
  localparam logic [7:0] RST_P0_PULLUP = 8'h00;
  localparam logic [3:0] RST_FLAG_EN   = 4'h0;
  localparam logic [7:0] RST_P1_MODE   = 8'h00;
  localparam logic [7:0] RST_P2_UPPER  = 8'h00;
  localparam logic [7:0] RST_P2_LOWER  = 8'h00;
  localparam logic [7:0] RST_P3_MODE   = 8'h00;
  localparam logic [3:0] RST_IRQ_EN    = 4'h0;

  // implemented bits
  localparam logic [7:0] MASK_P1_MODE   = 8'hdf;
  localparam logic [7:0] MASK_P2_UPPER  = 8'h7f;
  localparam logic [7:0] MASK_P2_PULLUP = 8'h7f;

  // field positions
  localparam int P1_OD1_BIT  = 7;
  localparam int P1_OD0_BIT  = 6;
  localparam int P1_P12_BIT  = 4;
  localparam int P1_P11_LSB  = 2;
  localparam int P1_P10_LSB  = 0;
  localparam int P2_P6_LSB   = 4;
  localparam int P2_P5_LSB   = 2;
  localparam int P2_P4_LSB   = 0;
  localparam int P0_PU_SPLIT = 4;
  localparam int FLAG_EN_OFS = 1;
  localparam int FLAG_PD_OFS = 0;
  localparam int NUM_EXT_IRQ = 4;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    P1M_IN    = 2'b00,
    P1M_IN_PU = 2'b01,
    P1M_OUT   = 2'b10,
    P1M_IN_PD = 2'b11
  } ppcei_p1_mode_type;

  // pins 3..0 of port 2; for pins 5,4 the last code is invalid
  typedef enum logic [1:0] {
    P2M_IN  = 2'b00,
    P2M_ALT = 2'b01,
    P2M_PP  = 2'b10,
    P2M_OD  = 2'b11
  } ppcei_p2_mode_type;

  typedef enum logic [2:0] {
    P6M_IN_A   = 3'b000,
    P6M_IN_B   = 3'b001,
    P6M_CONV_A = 3'b010,
    P6M_CONV_B = 3'b011,
    P6M_PP     = 3'b100,
    P6M_OD_PU  = 3'b101,
    P6M_OD     = 3'b110,
    P6M_CLK    = 3'b111
  } ppcei_p6_mode_type;

endpackage

/* rtl/ppcei_reg_if.sv */
// register access carrier between bus slave and register file
`timescale 1ns/1ps
interface ppcei_reg_if;
  logic       wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic       wr_hit;
  logic       rd_en;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  logic       rd_hit;

  modport bus
  (
    output wr_en, wr_idx, wr_data, rd_en, rd_idx,
    input  wr_hit, rd_data, rd_hit
  );
  modport regs
  (
    input  wr_en, wr_idx, wr_data, rd_en, rd_idx,
    output wr_hit, rd_data, rd_hit
  );
endinterface

/* rtl/ppcei_edge_irq.sv */
// falling edge detectors with sticky pending bits
`timescale 1ns/1ps
module ppcei_edge_irq #(
  parameter int N = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [N-1:0] pin_i,
  input  wire logic [N-1:0] watch_i,
  input  wire logic [N-1:0] en_i,
  input  wire logic [N-1:0] clr_i,
  output logic      [N-1:0] pend_o
);
  genvar k;
  generate
    for (k = 0; k < N; k++)
    begin : g_line
      logic prev_r;
      logic fall;
      // a line left idle low through reset raises no edge
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          prev_r <= 1'b0;
        else
          prev_r <= pin_i[k];
      end
      assign fall = prev_r & ~pin_i[k] & watch_i[k] & en_i[k];
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          pend_o[k] <= 1'b0;
        else
          pend_o[k] <= fall | (pend_o[k] & ~clr_i[k]);
      end
    end
  endgenerate
endmodule

/* rtl/ppcei_axil_slave.sv */
// axi4-lite slave that turns bus beats into register strobes
`timescale 1ns/1ps
module ppcei_axil_slave
  import ppcei_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] awaddr_i,
  input  wire logic              awvalid_i,
  output logic                   awready_o,
  input  wire logic [31:0]       wdata_i,
  input  wire logic [3:0]        wstrb_i,
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  output logic [1:0]             bresp_o,
  output logic                   bvalid_o,
  input  wire logic              bready_i,
  input  wire logic [ADDR_W-1:0] araddr_i,
  input  wire logic              arvalid_i,
  output logic                   arready_o,
  output logic [31:0]            rdata_o,
  output logic [1:0]             rresp_o,
  output logic                   rvalid_o,
  input  wire logic              rready_i,
  ppcei_reg_if.bus               rif
);
  logic       aw_full_r;
  logic       w_full_r;
  logic [7:0] aw_idx_r;
  logic [7:0] w_data_r;
  logic       w_lane_r;
  logic       aw_take;
  logic       w_take;
  logic       ar_take;
  logic       aw_full_nxt;
  logic       w_full_nxt;
  logic       bvalid_nxt;
  logic       rvalid_nxt;

  assign aw_take = awvalid_i & awready_o;
  assign w_take  = wvalid_i & wready_o;
  assign ar_take = arvalid_i & arready_o;

  // only byte lane 0 carries data; a write without it changes nothing
  assign rif.wr_en   = aw_full_r & w_full_r & ~bvalid_o & w_lane_r;
  assign rif.wr_idx  = aw_idx_r;
  assign rif.wr_data = w_data_r;
  assign rif.rd_en   = ar_take;
  assign rif.rd_idx  = araddr_i[9:2];

  always_comb
  begin
    aw_full_nxt = aw_full_r | aw_take;
    w_full_nxt  = w_full_r | w_take;
    bvalid_nxt  = bvalid_o & ~bready_i;
    if (aw_full_r & w_full_r & ~bvalid_o)
    begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
    end
    rvalid_nxt = ar_take | (rvalid_o & ~rready_i);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      bvalid_o  <= 1'b0;
      awready_o <= 1'b0;
      wready_o  <= 1'b0;
    end
    else
    begin
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      bvalid_o  <= bvalid_nxt;
      awready_o <= ~aw_full_nxt & ~bvalid_nxt;
      wready_o  <= ~w_full_nxt & ~bvalid_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_idx_r <= 8'h00;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
      bresp_o  <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        aw_idx_r <= awaddr_i[9:2];
      if (w_take)
      begin
        w_data_r <= wdata_i[7:0];
        w_lane_r <= wstrb_i[0];
      end
      if (aw_full_r & w_full_r & ~bvalid_o)
        bresp_o <= rif.wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rvalid_o  <= 1'b0;
      arready_o <= 1'b0;
      rdata_o   <= 32'h0000_0000;
      rresp_o   <= RESP_OKAY;
    end
    else
    begin
      rvalid_o  <= rvalid_nxt;
      arready_o <= ~rvalid_nxt;
      if (ar_take)
      begin
        rdata_o <= {24'h00_0000, rif.rd_data};
        rresp_o <= rif.rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end
endmodule

/* tb/ppcei_chk_sva.sv */
// port assertions for the pin configuration block
`timescale 1ns/1ps
module ppcei_chk (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic [1:0]  p1_pullup_o,
  input wire logic [1:0]  p1_pulldown_o,
  input wire logic [2:0]  p1_oe_o,
  input wire logic [2:0]  p1_out_o,
  input wire logic [2:0]  p1_in_en_o,
  input wire logic [6:0]  p2_oe_o,
  input wire logic [2:0]  conv_sel_o,
  input wire logic        uart_rxd_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_pu; (p1_pullup_o & p1_pulldown_o) == 2'b00; endproperty
  property p_pd; p1_pulldown_o[0] |-> p1_in_en_o[0] && !p1_oe_o[0]; endproperty
  property p_od; p1_oe_o[2] |-> !p1_out_o[2]; endproperty
  property p_cv6; conv_sel_o[0] |-> !p2_oe_o[6]; endproperty
  property p_cv54;
    (conv_sel_o[2:1] & {p2_oe_o[4], p2_oe_o[5]}) == 2'b00;
  endproperty
  property p_rx; p2_oe_o[2] |-> uart_rxd_o; endproperty
  property p_rd; s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0; endproperty
  // the mask or clear write lands a few cycles before irq drops
  property p_irq;
    $fell(irq_o) |-> s_axi_bvalid_o || $past(s_axi_bvalid_o)
      || $past(s_axi_bvalid_o, 2) || $past(s_axi_bvalid_o, 3);
  endproperty
  a_pu: assert property (p_pu) else $error("pull clash");
  a_pd: assert property (p_pd) else $error("pull-down drives");
  a_od: assert property (p_od) else $error("pin2 drives high");
  a_cv6: assert property (p_cv6) else $error("pin6 conv drives");
  a_cv54: assert property (p_cv54) else $error("pin5/4 conv drives");
  a_rx: assert property (p_rx) else $error("rxd not idle");
  a_rd: assert property (p_rd) else $error("upper rdata set");
  a_irq: assert property (p_irq) else $error("irq fell alone");
  c_irq: cover property ($rose(irq_o));
  c_pd: cover property (p1_pulldown_o[0]);
  c_cv: cover property (conv_sel_o == 3'h7);
endmodule
bind ppcei_top ppcei_chk u_chk (.*);

/* tb/ppcei_pins.sv */
// far-side pin model for port 2
`timescale 1ns/1ps
module ppcei_pins (
  input  wire logic [6:0] out_i,
  input  wire logic [6:0] oe_i,
  input  wire logic [6:0] pu_i,
  input  wire logic [6:0] ext_i,
  output logic      [6:0] pin_o
);
  // a released pin follows its pull-up, else the far-side level
  assign pin_o = oe_i & out_i | ~oe_i & (pu_i | ext_i);
endmodule

/* tb/port_pin_config_and_edge_irq_tb_top.sv */
// self-checking bench for the pin configuration block
`timescale 1ns/1ps
module port_pin_config_and_edge_irq_tb_top;
  import ppcei_pkg::*;
  logic clk_i = 0, resetn_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
  logic s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic clock_out_pin_fn_i = 0, uart_txd_i = 1, uart_rxd_out_i = 1;
  logic timer_one_match_i = 0, timer_zero_match_i = 0, irq_o;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, uart_rxd_o, timer_one_capture_o;
  logic [9:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hf, p0_pin_i = 4'hf, p0_is_input_i = 4'hf;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, p1_pullup_o, p1_pulldown_o, rs;
  logic [2:0] p1_data_i = 3'h3, p1_out_o, p1_oe_o, p1_in_en_o, conv_sel_o;
  logic [6:0] p2_data_i = 7'h04, p2_pin_i, p2_out_o, p2_oe_o, p2_pullup_o;
  logic [6:0] p2_in_en_o;
  logic [7:0] p0_pullup_o, rd_v;
  int bad_count = 0, total_checks = 0;
  always #20 clk_i = ~clk_i;
  ppcei_top uut (.*);
  // far side drives pin 2 low so the pull-up makes a visible difference
  ppcei_pins far_pins (.out_i(p2_out_o), .oe_i(p2_oe_o), .pu_i(p2_pullup_o),
    .ext_i(7'h51), .pin_o(p2_pin_i));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    s_axi_awaddr_i <= {a, 2'b00};
    s_axi_wdata_i <= {24'h0, d};
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    s_axi_bready_i <= 1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 0;
    end
    while (!s_axi_bvalid_o);
    rs = s_axi_bresp_o;
    s_axi_bready_i <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr_i <= {a, 2'b00};
    s_axi_arvalid_i <= 1;
    s_axi_rready_i <= 1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 0;
    end
    while (!s_axi_rvalid_o);
    rd_v = s_axi_rdata_o[7:0];
    rs = s_axi_rresp_o;
    s_axi_rready_i <= 0;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rd_v, e);
  endtask
  task w2;
    repeat (2) @(posedge clk_i);
  endtask
  task t_pull;
    chk(p0_pullup_o, 8'hf0);
    rc(IDX_P0_FLAGS, 8'h00);
    wr(IDX_P0_PULLUP, 8'h0f);
    w2;
    chk(p0_pullup_o, 8'hff);
    rc(IDX_P0_PULLUP, 8'h0f);
    wr(IDX_P2_PULLUP, 8'hff);
    rc(IDX_P2_PULLUP, 8'h7f);
    chk({1'b0, p2_pullup_o}, 8'h00);
    rc(8'h00, 8'h00);
    chk({6'h0, rs}, {6'h0, RESP_SLVERR});
  endtask
  task t_p1;
    wr(IDX_P1_MODE, 8'hff);
    rc(IDX_P1_MODE, 8'hdf);
    wr(IDX_P1_MODE, 8'h17);
    w2;
    chk({p1_pullup_o, p1_pulldown_o, p1_oe_o[2], p1_out_o[2]}, 8'h26);
    chk({5'h0, p1_in_en_o}, 8'h03);
    wr(IDX_P1_MODE, 8'h4a);
    w2;
    chk({p1_oe_o, p1_out_o}, 8'h12);
  endtask
  task t_p2;
    uart_txd_i <= 0;
    timer_zero_match_i <= 1;
    wr(IDX_P2_UPPER, 8'h25); // clock out left off
    wr(IDX_P2_LOWER, 8'h61);
    w2;
    chk({5'h0, conv_sel_o}, 8'h07);
    chk({p2_oe_o[3:0], p2_out_o[3:2], p2_out_o[0]}, 8'h6b);
  endtask
  task t_irq;
    wr(IDX_IRQ_EN, 8'h01);
    p0_pin_i <= 4'he;
    w2;
    rc(IDX_P0_FLAGS, 8'h00);
    p0_pin_i <= 4'hf;
    wr(IDX_P0_FLAGS, 8'h02);
    p0_pin_i <= 4'he;
    w2;
    rc(IDX_P0_FLAGS, 8'h03);
    rc(IDX_IRQ_STAT, 8'h01);
    chk({7'h0, irq_o}, 8'h01);
    wr(IDX_IRQ_EN, 8'h00);
    w2;
    chk({7'h0, irq_o}, 8'h00);
    wr(IDX_IRQ_EN, 8'h01);
    wr(IDX_P0_FLAGS, 8'h03);
    rc(IDX_P0_FLAGS, 8'h03);
    wr(IDX_P0_FLAGS, 8'h02);
    w2;
    rc(IDX_P0_FLAGS, 8'h02);
    chk({7'h0, irq_o}, 8'h00);
  endtask
  task t_misc;
    p0_pin_i <= 4'hf;
    w2;
    p0_pin_i <= 4'he;
    w2;
    rc(IDX_IRQ_STAT, 8'h01);
    wr(IDX_IRQ_CLR, 8'h01);
    rc(IDX_IRQ_STAT, 8'h00);
    rc(IDX_IRQ_CLR, 8'h00);
    wr(IDX_IRQ_STAT, 8'h01);
    chk({6'h0, rs}, {6'h0, RESP_SLVERR});
    p0_is_input_i <= 4'he;
    p0_pin_i <= 4'hf;
    w2;
    p0_pin_i <= 4'he;
    w2;
    rc(IDX_P0_FLAGS, 8'h02);
    wr(IDX_P3_MODE, 8'ha5);
    rc(IDX_P3_MODE, 8'ha5);
    wr(IDX_P2_LOWER, 8'h00);
    w2;
    chk({uart_rxd_o, timer_one_capture_o, p2_in_en_o[5:0]}, 8'h0f);
    wr(IDX_P2_PULLUP, 8'h7b);
    w2;
    chk({6'h0, uart_rxd_o, timer_one_capture_o}, 8'h03);
    wr(IDX_P2_UPPER, 8'h59);
    w2;
    chk({p2_oe_o[6:4], p2_pullup_o[6], 1'b0, conv_sel_o}, 8'hd4);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1;
    repeat (6) @(posedge clk_i);
    t_pull;
    t_p1;
    t_p2;
    t_irq;
    t_misc;
    finish_test;
  end
  initial
  begin
    #100000;
    bad_count++;
    finish_test;
  end
endmodule
